// File: mmp_consts.svh
`ifndef MMP_CONSTS_SVH
`define MMP_CONSTS_SVH

// ****************************************************************
// Bus address and memory layout
// ****************************************************************
`define MMP_DEV_ADDR        7'h50
`define MMP_IDENT_BYTE      8'h00
`define MMP_STAT1_BYTE      8'h01
`define MMP_STATUS_BYTE     8'h02
`define MMP_NOT_READY_BIT   0
`define MMP_FLAG_FIRST      8'h03
`define MMP_FLAG_LAST       8'h15
`define MMP_FLAG_BYTES      19
`define MMP_MON_FIRST       7'h16
`define MMP_MON_LAST        7'h51
`define MMP_RW_FIRST        7'h56
`define MMP_CTRL_FIRST      86
`define MMP_CTRL_BYTES      12
`define MMP_MASK_FIRST      100
`define MMP_MASK_BYTES      7
`define MMP_PAGE_SEL        127
`define MMP_LOWER_BYTES     128
`define MMP_PAGE_BITS       2
`define MMP_PAGE_USER       2'h2
`define MMP_PAGE_THRESH     2'h3
`define MMP_UPPER_RW_FIRST  7'h62
`define MMP_ZERO_BYTE       8'h00

// ****************************************************************
// Pin reset levels: scl, sda, select_n, reset_n high; low power off
// ****************************************************************
`define MMP_PIN_RST         5'h1E

// ****************************************************************
// Timing
// ****************************************************************
`define MMP_CLK_KHZ         10000
`define MMP_RESET_MIN_NS    2000
`define MMP_RESET_MIN_CYC   ((`MMP_RESET_MIN_NS * `MMP_CLK_KHZ + 999999) / 1000000)
`define MMP_INIT_MS         2000
`define MMP_INIT_CYC        (`MMP_INIT_MS * `MMP_CLK_KHZ)

`endif

// File: mmp_pkg.sv
package mmp_pkg;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef struct packed {
    logic       scl;
    logic       sda;
    logic       sel_n;
    logic       rst_n;
    logic       lp;
  } mmp_pins_t;

  typedef struct packed {
    logic       we;
    logic [1:0] page;
    logic [7:0] addr;
    logic [7:0] data;
  } mmp_mon_wr_t;

  typedef enum {
    S_IDLE,
    S_ADDR,
    S_ADDR_ACK,
    S_WR,
    S_WR_ACK,
    S_RD,
    S_RD_ACK
  } mmp_i2c_state_t;

endpackage : mmp_pkg

// File: mmp_sync.sv
`timescale 1ns/1ns
module mmp_sync #(
  parameter int           W       = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // Clock and reset
  input  wire logic         clock_i,
  input  wire logic         rst_i,
  // Data
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);

  logic [W-1:0] meta;

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      meta <= RST_VAL;
      q_o  <= RST_VAL;
    end else begin
      meta <= d_i;
      q_o  <= meta;
    end
  end

endmodule : mmp_sync

// File: mmp_port.sv
// How it works
// - Select low: answer bus commands
// - Select high: ignore bus, leave data line undriven
// - Select defaults high, module deselected
// - Reset input defaults high, not reset
// - Long reset low restores lower-page writable settings only
// - Init interval starts at reset rising edge
// - Fully functional within 2000 ms
// - Completion: interrupt with not-ready bit cleared
// - Power-up raises completion interrupt unprompted
// - Low power request lowers consumption level
// - Presence output tied low in module
// - Interrupt low reports fault or status
// - Interrupt is open collector, host pulls up
// - Lower page 128 bytes plus paged upper
// - Flags and monitors low, IDs upper
// - Answer address A0h, flags in one read
// - Not-ready is status byte 2 bit 0
// - Reading flags clears them, interrupt released
`include "mmp_consts.svh"
`timescale 1ns/1ns
module mmp_port #(
  parameter int         INIT_CYCLES = `MMP_INIT_CYC,
  parameter logic [7:0] IDENT       = 8'h5A,
  parameter int         FLAG_BITS   = `MMP_FLAG_BYTES * 8
) (
  // Clock and reset
  input  wire logic                 clock_i,
  input  wire logic                 rst_i,
  // Host control pins
  input  wire logic                 module_select_n_i,
  input  wire logic                 module_reset_n_i,
  input  wire logic                 low_power_request_i,
  // 2-wire bus
  input  wire logic                 scl_i,
  input  wire logic                 sda_i,
  output logic                      sda_o,
  output logic                      sda_oe_o,
  // Status pins
  output logic                      interrupt_n_o,
  output logic                      interrupt_oe_o,
  output logic                      module_present_n_o,
  // Module internal side
  input  mmp_pkg::mmp_mon_wr_t      mon_wr_i,
  input  wire logic [FLAG_BITS-1:0] flag_event_i,
  output logic [`MMP_CTRL_BYTES*8-1:0] ctrl_o,
  output logic                      low_power_o,
  output logic                      device_reset_o,
  output logic                      functional_o
);
  import mmp_pkg::*;

  // ****************************************************************
  // Pin synchronisers and edge detection
  // ****************************************************************
  mmp_pins_t pins_raw;
  mmp_pins_t pins_s;
  logic      scl_d;
  logic      sda_d;

  assign pins_raw = '{scl: scl_i, sda: sda_i, sel_n: module_select_n_i,
                      rst_n: module_reset_n_i, lp: low_power_request_i};

  mmp_sync #(
    .W       (5),
    .RST_VAL (`MMP_PIN_RST)
  ) u_sync (
    .clock_i (clock_i),
    .rst_i   (rst_i),
    .d_i     (pins_raw),
    .q_o     (pins_s)
  );

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      scl_d <= pins_s.scl;
      sda_d <= pins_s.sda;
    end
  end

  logic scl_rise;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;
  logic selected;

  assign scl_rise  = pins_s.scl & ~scl_d;
  assign scl_fall  = ~pins_s.scl & scl_d;
  assign bus_start = pins_s.scl & scl_d & sda_d & ~pins_s.sda;
  assign bus_stop  = pins_s.scl & scl_d & ~sda_d & pins_s.sda;
  assign selected  = ~pins_s.sel_n;

  // ****************************************************************
  // Reset request and initialisation timing
  // ****************************************************************
  logic [15:0] low_cnt;
  logic        reset_req;
  logic        rst_n_d;
  logic [31:0] init_cnt;
  logic        init_busy;
  logic        not_ready;
  logic        soft_reset;

  assign soft_reset = reset_req & ~pins_s.rst_n;

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      low_cnt   <= 16'h0000;
      reset_req <= 1'b0;
      rst_n_d   <= 1'b1;
    end else begin
      rst_n_d <= pins_s.rst_n;
      if (pins_s.rst_n) begin
        low_cnt <= 16'h0000;
      end else if (low_cnt < 16'(`MMP_RESET_MIN_CYC)) begin
        low_cnt <= low_cnt + 16'h0001;
      end
      if (!pins_s.rst_n && low_cnt >= 16'(`MMP_RESET_MIN_CYC - 1)) begin
        reset_req <= 1'b1;
      end else if (pins_s.rst_n && !rst_n_d) begin
        reset_req <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      init_cnt  <= 32'h00000000;
      init_busy <= 1'b1;
      not_ready <= 1'b1;
    end else if (soft_reset) begin
      init_cnt  <= 32'h00000000;
      init_busy <= 1'b1;
      not_ready <= 1'b1;
    end else if (init_busy && (reset_req || low_cnt == 16'h0000)) begin
      if (reset_req) begin
        init_cnt <= 32'h00000000;
      end else if (init_cnt >= 32'(INIT_CYCLES - 1)) begin
        init_busy <= 1'b0;
        not_ready <= 1'b0;
      end else begin
        init_cnt <= init_cnt + 32'h00000001;
      end
    end
  end

  // ****************************************************************
  // 2-wire target
  // ****************************************************************
  mmp_i2c_state_t state;
  logic [7:0]     shift;
  logic [3:0]     bit_cnt;
  logic [7:0]     ptr;
  logic           ptr_pending;
  logic           nack;
  logic           host_wr;
  logic           host_wr_ok;
  logic [7:0]     wr_addr;
  logic [7:0]     wr_data;
  logic           rd_load;
  logic [7:0]     rd_addr;
  logic [7:0]     rd_data;
  logic [7:0]     lower_mem [`MMP_LOWER_BYTES];
  logic [7:0]     flag_q    [`MMP_FLAG_BYTES];
  logic [7:0]     upper_mem [(2**`MMP_PAGE_BITS) * `MMP_LOWER_BYTES];
  logic [`MMP_PAGE_BITS-1:0] page;

  assign page = lower_mem[`MMP_PAGE_SEL][`MMP_PAGE_BITS-1:0];

  function automatic logic writable(input logic [7:0] a, input logic [1:0] pg);
    if (!a[7]) begin
      writable = a[6:0] >= `MMP_RW_FIRST;
    end else begin
      writable = (pg == `MMP_PAGE_USER) ||
                 (pg == `MMP_PAGE_THRESH && a[6:0] >= `MMP_UPPER_RW_FIRST);
    end
  endfunction : writable

  // Read data for the byte at the pointer
  always_comb begin
    rd_data = `MMP_ZERO_BYTE;
    if (ptr[7]) begin
      rd_data = upper_mem[{page, ptr[6:0]}];
    end else if (ptr >= `MMP_FLAG_FIRST && ptr <= `MMP_FLAG_LAST) begin
      rd_data = flag_q[5'(ptr - `MMP_FLAG_FIRST)];
    end else if (ptr == `MMP_STATUS_BYTE) begin
      rd_data = `MMP_ZERO_BYTE;
      rd_data[`MMP_NOT_READY_BIT] = not_ready;
    end else if (ptr == `MMP_STAT1_BYTE) begin
      rd_data = `MMP_ZERO_BYTE;
    end else if (ptr == `MMP_IDENT_BYTE) begin
      rd_data = IDENT;
    end else begin
      rd_data = lower_mem[ptr[6:0]];
    end
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      state       <= S_IDLE;
      shift       <= 8'h00;
      bit_cnt     <= 4'h0;
      ptr         <= 8'h00;
      ptr_pending <= 1'b0;
      nack        <= 1'b0;
      sda_oe_o    <= 1'b0;
      host_wr     <= 1'b0;
      host_wr_ok  <= 1'b0;
      wr_addr     <= 8'h00;
      wr_data     <= 8'h00;
      rd_load     <= 1'b0;
      rd_addr     <= 8'h00;
    end else begin
      host_wr <= 1'b0;
      rd_load <= 1'b0;
      if (!selected || bus_stop) begin
        state    <= S_IDLE;
        sda_oe_o <= 1'b0;
      end else if (bus_start) begin
        state    <= S_ADDR;
        bit_cnt  <= 4'h0;
        sda_oe_o <= 1'b0;
      end else begin
        case (state)
          S_IDLE: begin
            sda_oe_o <= 1'b0;
          end
          S_ADDR: begin
            if (scl_rise) begin
              shift   <= {shift[6:0], pins_s.sda};
              bit_cnt <= bit_cnt + 4'h1;
            end else if (scl_fall && bit_cnt == 4'h8) begin
              if (shift[7:1] == `MMP_DEV_ADDR) begin
                state    <= S_ADDR_ACK;
                sda_oe_o <= 1'b1;
                nack     <= shift[0];
              end else begin
                state <= S_IDLE;
              end
            end
          end
          S_ADDR_ACK: begin
            if (scl_fall) begin
              bit_cnt <= 4'h0;
              if (nack) begin
                state    <= S_RD;
                shift    <= rd_data;
                sda_oe_o <= ~rd_data[7];
                rd_load  <= 1'b1;
                rd_addr  <= ptr;
                ptr      <= ptr + 8'h01;
              end else begin
                state       <= S_WR;
                ptr_pending <= 1'b1;
                sda_oe_o    <= 1'b0;
              end
            end
          end
          S_WR: begin
            if (scl_rise) begin
              shift   <= {shift[6:0], pins_s.sda};
              bit_cnt <= bit_cnt + 4'h1;
            end else if (scl_fall && bit_cnt == 4'h8) begin
              state    <= S_WR_ACK;
              sda_oe_o <= 1'b1;
              if (ptr_pending) begin
                ptr <= shift;
              end else begin
                host_wr    <= 1'b1;
                host_wr_ok <= writable(ptr, page);
                wr_addr    <= ptr;
                wr_data    <= shift;
                ptr        <= ptr + 8'h01;
              end
            end
          end
          S_WR_ACK: begin
            if (scl_fall) begin
              state       <= S_WR;
              bit_cnt     <= 4'h0;
              ptr_pending <= 1'b0;
              sda_oe_o    <= 1'b0;
            end
          end
          S_RD: begin
            if (scl_fall) begin
              if (bit_cnt == 4'h7) begin
                state    <= S_RD_ACK;
                sda_oe_o <= 1'b0;
              end else begin
                shift    <= {shift[6:0], 1'b0};
                sda_oe_o <= ~shift[6];
                bit_cnt  <= bit_cnt + 4'h1;
              end
            end
          end
          S_RD_ACK: begin
            if (scl_rise) begin
              nack <= pins_s.sda;
            end else if (scl_fall) begin
              if (nack) begin
                state <= S_IDLE;
              end else begin
                state    <= S_RD;
                bit_cnt  <= 4'h0;
                shift    <= rd_data;
                sda_oe_o <= ~rd_data[7];
                rd_load  <= 1'b1;
                rd_addr  <= ptr;
                ptr      <= ptr + 8'h01;
              end
            end
          end
          default: begin
            state    <= S_IDLE;
            sda_oe_o <= 1'b0;
          end
        endcase
      end
    end
  end

  assign sda_o = 1'b0;

  // ****************************************************************
  // Lower and upper page storage
  // ****************************************************************
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      for (int i = 0; i < `MMP_LOWER_BYTES; i++) begin
        lower_mem[i] <= 8'h00;
      end
    end else begin
      for (int i = 0; i < `MMP_LOWER_BYTES; i++) begin
        if (soft_reset && 7'(i) >= `MMP_RW_FIRST) begin
          lower_mem[i] <= 8'h00;
        end else if (host_wr && host_wr_ok && !wr_addr[7] && wr_addr[6:0] == 7'(i)) begin
          lower_mem[i] <= wr_data;
        end else if (mon_wr_i.we && !mon_wr_i.addr[7] && mon_wr_i.addr[6:0] == 7'(i) &&
                     7'(i) >= `MMP_MON_FIRST && 7'(i) <= `MMP_MON_LAST) begin
          lower_mem[i] <= mon_wr_i.data;
        end
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (host_wr && host_wr_ok && wr_addr[7]) begin
      upper_mem[{page, wr_addr[6:0]}] <= wr_data;
    end else if (mon_wr_i.we && mon_wr_i.addr[7]) begin
      upper_mem[{mon_wr_i.page, mon_wr_i.addr[6:0]}] <= mon_wr_i.data;
    end
  end

  always_comb begin
    for (int k = 0; k < `MMP_CTRL_BYTES; k++) begin
      ctrl_o[k*8 +: 8] = lower_mem[`MMP_CTRL_FIRST + k];
    end
  end

  // ****************************************************************
  // Latched flags, clear on read, new events win
  // ****************************************************************
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      for (int i = 0; i < `MMP_FLAG_BYTES; i++) begin
        flag_q[i] <= 8'h00;
      end
    end else begin
      for (int i = 0; i < `MMP_FLAG_BYTES; i++) begin
        if (rd_load && rd_addr == `MMP_FLAG_FIRST + 8'(i)) begin
          flag_q[i] <= flag_event_i[i*8 +: 8];
        end else begin
          flag_q[i] <= flag_q[i] | flag_event_i[i*8 +: 8];
        end
      end
    end
  end

  // ****************************************************************
  // Reset completion and interrupt output
  // ****************************************************************
  logic complete;
  logic flag_pend;
  logic int_active;

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      complete <= 1'b0;
    end else if (soft_reset) begin
      complete <= 1'b0;
    end else if (init_busy && !reset_req && low_cnt == 16'h0000 &&
                 init_cnt >= 32'(INIT_CYCLES - 1)) begin
      complete <= 1'b1;
    end else if (rd_load && rd_addr == `MMP_STATUS_BYTE) begin
      complete <= 1'b0;
    end
  end

  always_comb begin
    flag_pend = 1'b0;
    for (int k = 0; k < `MMP_FLAG_BYTES; k++) begin
      if (k < `MMP_MASK_BYTES) begin
        flag_pend = flag_pend | (|(flag_q[k] & ~lower_mem[`MMP_MASK_FIRST + k]));
      end else begin
        flag_pend = flag_pend | (|flag_q[k]);
      end
    end
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      int_active     <= 1'b0;
      low_power_o    <= 1'b0;
      device_reset_o <= 1'b0;
      functional_o   <= 1'b0;
    end else begin
      int_active     <= complete | (~init_busy & flag_pend);
      low_power_o    <= pins_s.lp;
      device_reset_o <= soft_reset;
      functional_o   <= ~init_busy;
    end
  end

  assign interrupt_n_o      = 1'b0;
  assign interrupt_oe_o     = int_active;
  assign module_present_n_o = 1'b0;

endmodule : mmp_port

// File: mmp_port_checker.sv
`include "mmp_consts.svh"
`timescale 1ns/1ns
module mmp_port_checker #(
  parameter int INIT_CYCLES = 200
) (
  // Clock and reset
  input wire logic                       clock_i,
  input wire logic                       rst_i,
  // Host control pins
  input wire logic                       module_select_n_i,
  input wire logic                       module_reset_n_i,
  input wire logic                       low_power_request_i,
  // Outputs
  input wire logic                       sda_o,
  input wire logic                       sda_oe_o,
  input wire logic                       interrupt_n_o,
  input wire logic                       interrupt_oe_o,
  input wire logic                       module_present_n_o,
  input wire logic [`MMP_CTRL_BYTES*8-1:0] ctrl_o,
  input wire logic                       low_power_o,
  input wire logic                       device_reset_o,
  input wire logic                       functional_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);

  // ********
  // Cycles since the last reset release
  // ********
  logic [31:0] since;
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      since <= 32'h0;
    end else if (device_reset_o) begin
      since <= 32'h0;
    end else if (since != 32'hFFFFFFFF) begin
      since <= since + 32'h1;
    end
  end

  chk_present_low: assert property (module_present_n_o == 1'b0)
    else $error("presence output not low");
  chk_open_drain: assert property (!interrupt_n_o && !sda_o)
    else $error("open drain data not low");
  chk_desel_quiet: assert property (module_select_n_i [*5] |-> !sda_oe_o)
    else $error("bus driven while deselected");
  chk_reset_clears: assert property (device_reset_o [*2] |-> ctrl_o == '0 && !functional_o)
    else $error("settings not cleared in reset");
  chk_short_reset: assert property (module_reset_n_i [*6] |-> !device_reset_o)
    else $error("reset held after release");
  chk_init_time: assert property ($rose(functional_o) |->
      since >= INIT_CYCLES - 4 && since <= INIT_CYCLES + 6)
    else $error("init interval length wrong");
  chk_done_irq: assert property ($rose(functional_o) |-> ##[0:2] interrupt_oe_o)
    else $error("no completion interrupt");
  chk_reset_noirq: assert property (device_reset_o [*2] |-> !interrupt_oe_o)
    else $error("interrupt during reset");
  chk_lp_high: assert property (low_power_request_i [*5] |-> low_power_o)
    else $error("low power not followed");
  chk_lp_low: assert property (!low_power_request_i [*5] |-> !low_power_o)
    else $error("low power stuck");

  cover property ($rose(functional_o));
  cover property ($fell(interrupt_oe_o));
  cover property ($rose(device_reset_o));
  cover property ($rose(sda_oe_o));
endmodule : mmp_port_checker

bind mmp_port mmp_port_checker #(.INIT_CYCLES(INIT_CYCLES)) u_chk (
  .clock_i(clock_i), .rst_i(rst_i), .module_select_n_i(module_select_n_i),
  .module_reset_n_i(module_reset_n_i), .low_power_request_i(low_power_request_i),
  .sda_o(sda_o), .sda_oe_o(sda_oe_o), .interrupt_n_o(interrupt_n_o),
  .interrupt_oe_o(interrupt_oe_o), .module_present_n_o(module_present_n_o),
  .ctrl_o(ctrl_o), .low_power_o(low_power_o), .device_reset_o(device_reset_o),
  .functional_o(functional_o));

// File: mmp_host_model.sv
`timescale 1ns/1ns
module mmp_host_model (
  // Clock
  input  wire logic clock_i,
  // Wired bus level
  input  wire logic sda_line_i,
  // Host drive, 1 releases the line
  output logic      scl_o,
  output logic      sda_o
);
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end

  task automatic hold;
    repeat (4) @(posedge clock_i);
  endtask : hold

  // ********
  // Bus conditions, one bit is 900 ns; clock idles high
  // ********
  task automatic start_cond;
    @(posedge clock_i);
    sda_o <= 1'b1;
    hold;
    scl_o <= 1'b1;
    hold;
    sda_o <= 1'b0;
    hold;
    scl_o <= 1'b0;
    @(posedge clock_i);
  endtask : start_cond

  task automatic stop_cond;
    sda_o <= 1'b0;
    hold;
    scl_o <= 1'b1;
    hold;
    sda_o <= 1'b1;
    hold;
  endtask : stop_cond

  // Data moves only while the clock is low
  task automatic bit_cyc(input logic b, output logic r);
    sda_o <= b;
    hold;
    scl_o <= 1'b1;
    hold;
    r = sda_line_i;
    scl_o <= 1'b0;
    @(posedge clock_i);
  endtask : bit_cyc

  task automatic xbyte(input logic [7:0] d, input logic ack_i,
                       output logic [7:0] q, output logic ack_o);
    for (int i = 7; i >= 0; i--) begin
      bit_cyc(d[i], q[i]);
    end
    bit_cyc(ack_i, ack_o);
  endtask : xbyte
endmodule : mmp_host_model

// File: mmp_port_tb.sv
`include "mmp_consts.svh"
`timescale 1ns/1ns
`define CHK(nm, exp, got) begin comparisons++; if ((got) !== (exp)) begin bad_count++; \
  $display("unexpected %s expected %h seen %h", nm, exp, got); end end
module mmp_port_tb;
  import mmp_pkg::*;
  logic                             clock_i, rst_i, select_n, reset_n, lp_req;
  mmp_mon_wr_t                      mon_wr;
  logic [`MMP_FLAG_BYTES*8-1:0]     flag_ev;
  logic                             sda_oe, int_oe, present_n, lp, dev_rst, func;
  logic [`MMP_CTRL_BYTES*8-1:0]     ctrl;
  wire logic                        host_scl, host_sda;
  wire logic                        sda_line = host_sda & ~sda_oe;
  wire logic                        int_line = ~int_oe;
  int                               bad_count, comparisons, cycles;
  logic [7:0]                       q;
  logic                             a;

  mmp_host_model host (.clock_i(clock_i), .sda_line_i(sda_line), .scl_o(host_scl),
                       .sda_o(host_sda));
  mmp_port #(.INIT_CYCLES(200), .IDENT(8'h3C)) DUT ( // IDENT value is arbitrary
    .clock_i(clock_i), .rst_i(rst_i), .module_select_n_i(select_n),
    .module_reset_n_i(reset_n), .low_power_request_i(lp_req), .scl_i(host_scl),
    .sda_i(sda_line), .sda_o(), .sda_oe_o(sda_oe), .interrupt_n_o(),
    .interrupt_oe_o(int_oe), .module_present_n_o(present_n), .mon_wr_i(mon_wr),
    .flag_event_i(flag_ev), .ctrl_o(ctrl), .low_power_o(lp),
    .device_reset_o(dev_rst), .functional_o(func));

  always #50 clock_i = ~clock_i;

  // ********
  // Bus helpers
  // ********
  task automatic tx(input logic [7:0] d);
    logic [7:0] r;
    logic       k;
    host.xbyte(d, 1'b1, r, k);
    `CHK("ack", 1'b0, k)
  endtask : tx

  task automatic wr(input logic [7:0] p, input logic [7:0] d);
    host.start_cond;
    tx(8'hA0);
    tx(p);
    tx(d);
    host.stop_cond;
  endtask : wr

  task automatic rd(input logic [7:0] p, output logic [7:0] d);
    logic k;
    host.start_cond;
    tx(8'hA0);
    tx(p);
    host.start_cond;
    tx(8'hA1);
    host.xbyte(8'hFF, 1'b1, d, k);
    host.stop_cond;
  endtask : rd

  task automatic wait_int;
    for (int i = 0; i < 400 && int_line !== 1'b0; i++) @(posedge clock_i);
  endtask : wait_int

  // ********
  // Scenarios
  // ********
  task automatic t_power;
    wait_int;
    `CHK("int", 1'b0, int_line)
    `CHK("func", 1'b1, func)
    `CHK("present", 1'b0, present_n)
    rd(8'h00, q);
    `CHK("ident", 8'h3C, q)
    rd(8'h02, q);
    `CHK("status", 8'h00, q)
    `CHK("int", 1'b1, int_line)
  endtask : t_power

  task automatic t_rw;
    host.start_cond;
    tx(8'hA0);
    tx(8'h56);
    tx(8'h12);
    tx(8'h34);
    host.stop_cond;
    `CHK("ctrl", 16'h3412, ctrl[15:0])
    rd(8'h57, q);
    `CHK("byte87", 8'h34, q)
    host.start_cond;
    host.xbyte(8'hA2, 1'b1, q, a);
    `CHK("other addr ack", 1'b1, a)
    host.stop_cond;
  endtask : t_rw

  task automatic t_desel;
    select_n <= 1'b1;
    repeat (3) @(posedge clock_i);
    host.start_cond;
    host.xbyte(8'hA0, 1'b1, q, a);
    `CHK("desel ack", 1'b1, a)
    host.stop_cond;
    select_n <= 1'b0;
  endtask : t_desel

  task automatic t_page;
    mon_wr <= '{1'b1, 2'h0, 8'h80, 8'hC3};
    @(posedge clock_i);
    mon_wr <= '{1'b1, 2'h0, 8'h16, 8'h77};
    @(posedge clock_i);
    mon_wr <= '0;
    wr(8'h7F, 8'h02);
    wr(8'h80, 8'hA5);
    wr(8'h7F, 8'h03);
    wr(8'hE2, 8'h5C);
    rd(8'hE2, q);
    `CHK("page3", 8'h5C, q)
    wr(8'h7F, 8'h02);
    rd(8'h80, q);
    `CHK("page2", 8'hA5, q)
    wr(8'h7F, 8'h00);
    rd(8'h80, q);
    `CHK("page0", 8'hC3, q)
    wr(8'h16, 8'h00);
    rd(8'h16, q);
    `CHK("monitor", 8'h77, q)
  endtask : t_page

  task automatic t_flag;
    flag_ev[0] <= 1'b1;
    @(posedge clock_i);
    flag_ev[0] <= 1'b0;
    wait_int;
    `CHK("flag int", 1'b0, int_line)
    rd(8'h03, q);
    `CHK("flag", 8'h01, q)
    `CHK("int off", 1'b1, int_line)
    rd(8'h03, q);
    `CHK("flag clr", 8'h00, q)
    wr(8'h64, 8'h01);
    flag_ev[0] <= 1'b1;
    @(posedge clock_i);
    flag_ev[0] <= 1'b0;
    repeat (5) @(posedge clock_i);
    `CHK("masked", 1'b1, int_line)
    rd(8'h03, q);
    `CHK("flag kept", 8'h01, q)
    wr(8'h64, 8'h00);
  endtask : t_flag

  task automatic t_reset;
    lp_req <= 1'b1;
    repeat (5) @(posedge clock_i);
    `CHK("lp", 1'b1, lp)
    lp_req <= 1'b0;
    reset_n <= 1'b0;
    repeat (10) @(posedge clock_i);
    reset_n <= 1'b1;
    repeat (5) @(posedge clock_i);
    `CHK("short", 16'h3412, ctrl[15:0])
    reset_n <= 1'b0;
    repeat (30) @(posedge clock_i);
    `CHK("dev rst", 1'b1, dev_rst)
    `CHK("ctrl clr", 16'h0000, ctrl[15:0])
    reset_n <= 1'b1;
    wait_int;
    `CHK("func", 1'b1, func)
    rd(8'h02, q);
    `CHK("status", 8'h00, q)
  endtask : t_reset

  task automatic end_sim;
    $display("comparisons %0d bad_count %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : end_sim

  always @(posedge clock_i) begin
    cycles++;
    if (cycles == 30000) begin
      bad_count++;
      end_sim;
    end
  end

  initial begin
    clock_i = 1'b0;
    rst_i = 1'b1;
    select_n = 1'b0;
    reset_n = 1'b1;
    lp_req = 1'b0;
    mon_wr = '0;
    flag_ev = '0;
    repeat (2) @(posedge clock_i);
    rst_i <= 1'b0;
    t_power;
    t_rw;
    t_desel;
    t_page;
    t_flag;
    t_reset;
    end_sim;
  end
endmodule : mmp_port_tb
